// ### shared/pwm_sync_regs.svh
// Named constants for the PWM synchronisation, deadtime and mask stage
`ifndef PWM_SYNC_REGS_SVH
`define PWM_SYNC_REGS_SVH

// ----------------------------------------------------------------------
// Write target select codes
// ----------------------------------------------------------------------
`define PWM_SEL_CNTIN   4'h0
`define PWM_SEL_MOD     4'h1
`define PWM_SEL_CV0     4'h2
`define PWM_SEL_CV5     4'h7
`define PWM_SEL_MASK    4'h8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PWM_CNT_RST     16'h0000
`define PWM_CNTIN_RST   16'h0000
`define PWM_MOD_RST     16'hffff
`define PWM_CV_RST      16'h0000
`define PWM_MASK_RST    6'h00
`define PWM_TRIG_RST    3'h0
`define PWM_DT_ZERO     6'h00

// ----------------------------------------------------------------------
// Deadtime prescaler codes and last count of each divider
// ----------------------------------------------------------------------
`define PWM_DEADTIME_PRESCALE_DIV4   2'h2
`define PWM_DEADTIME_PRESCALE_DIV16  2'h3
`define PWM_PS_DIV1     4'h0
`define PWM_PS_DIV4     4'h3
`define PWM_PS_DIV16    4'hf
`define PWM_PS_STEP     4'h1
`define PWM_CNT_STEP    16'h0001
`define PWM_DT_STEP     6'h01

`endif

// ### shared/pwm_sync_pkg.sv
// Types for the PWM synchronisation, deadtime and mask stage
package pwm_sync_pkg;

  // ----------------------------------------------------------------------
  // State of one deadtime pair
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       a_prev;
    logic       b_prev;
    logic [5:0] dly;
    logic       a_out;
    logic       b_out;
  } dt_state_t;

  // ----------------------------------------------------------------------
  // State of the top stage
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       cntin;
    logic [15:0]       cntin_buf;
    logic              cntin_hi;
    logic              cntin_lo;
    logic [15:0]       modv;
    logic [15:0]       mod_buf;
    logic              mod_hi;
    logic              mod_lo;
    logic [5:0][15:0]  cv;
    logic [5:0][15:0]  cv_buf;
    logic [5:0]        cv_hi;
    logic [5:0]        cv_lo;
    logic [5:0]        mask_buf;
    logic [5:0]        mask;
    logic              soft_sync_trigger;
    logic              pend_hw;
    logic [2:0]        trig_en;
    logic [2:0]        trig_prev;
    logic [3:0]        ps_cnt;
    logic              dt_tick;
    logic              ovf;
    logic [5:0]        pwm;
  } pwm_state_t;

endpackage : pwm_sync_pkg

// ### verilog/pwm_deadtime_pair.sv
// Deadtime insertion for one complementary channel pair
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_regs.svh"

module pwm_deadtime_pair (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       a_i,        // Wanted active state, channel n
  input  wire logic       b_i,        // Wanted active state, channel n+1
  input  wire logic       dt_on_i,    // Deadtime active for this pair
  input  wire logic       tick_i,     // Prescaled deadtime clock
  input  wire logic [5:0] count_i,    // Deadtime length in ticks
  output logic            a_o,
  output logic            b_o
);

  pwm_sync_pkg::dt_state_t s_q;
  pwm_sync_pkg::dt_state_t s_d;
  logic                    edge_seen;

  // ----------------------------------------------------------------------
  // Delay counter and output blanking
  // ----------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    edge_seen  = (a_i != s_q.a_prev) || (b_i != s_q.b_prev);
    s_d.a_prev = a_i;
    s_d.b_prev = b_i;
    if (!dt_on_i) begin
      s_d.dly   = `PWM_DT_ZERO;
      s_d.a_out = a_i;
      s_d.b_out = b_i;
    end else if (edge_seen) begin
      s_d.dly   = count_i;           // Full delay for every edge
      s_d.a_out = 1'b0;              // Both held inactive
      s_d.b_out = 1'b0;
    end else if (s_q.dly != `PWM_DT_ZERO) begin
      s_d.a_out = 1'b0;
      s_d.b_out = 1'b0;
      if (tick_i) begin
        s_d.dly = s_q.dly - `PWM_DT_STEP;   // Count prescaled periods
        // Last tick releases the pair, so the delay is exactly count ticks
        if (s_q.dly == `PWM_DT_STEP) begin
          s_d.a_out = a_i;
          s_d.b_out = b_i & ~a_i;
        end
      end
    end else begin
      s_d.a_out = a_i;
      s_d.b_out = b_i & ~a_i;        // Never both active
    end
    if (srst_i) begin
      s_d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    s_q <= s_d;
  end

  assign a_o = s_q.a_out;
  assign b_o = s_q.b_out;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_no_overlap;
    @(posedge clk_sys_i) disable iff (srst_i)
    $past(dt_on_i) |-> !(a_o && b_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair both active");

  property p_edge_blank;
    @(posedge clk_sys_i) disable iff (srst_i)
    (dt_on_i && edge_seen && count_i > `PWM_DT_STEP) ##1 dt_on_i |-> (!a_o && !b_o) [*2];
  endproperty
  a_edge_blank: assert property (p_edge_blank) else $error("edge not delayed");

endmodule : pwm_deadtime_pair
`default_nettype wire

// ### verilog/pwm_sync_deadtime_mask.sv
// PWM buffered-register synchronisation, deadtime insertion and output mask
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_regs.svh"

// Contract
// - Initial value applies after both bytes, next overflow/sync
// - Trigger then boundary loads modulo and compares
// - Immediate mode loads modulo/compares on trigger
// - Sync mode one: software trigger, boundary load
// - Compare loads only with pair sync enabled
// - Trigger mode forces counter to initial value
// - Unsynced mask write applies next clock edge
// - Synced mask loads from buffer on trigger
// - Device clears software trigger when sync done
// - Hardware trigger enable clears on its event
// - Deadtime needs enable and non-zero count
// - Delay is count prescaled periods, shared
// - Pair never active together under deadtime
// - Active-high: rising edges delayed by deadtime
// - Active-low: falling edges delayed by deadtime
// - Deadtime only in combine or complementary mode
// - Short channel n pulse stays inactive
// - Short channel n+1 pulse stays inactive
// - Mask writes land in a write buffer
// - Masked channel driven to inactive level
// - Mask applies only in combine mode
// - Boundaries: counter reaches initial or modulo
// - Writing one to software trigger starts sync
// - Hardware trigger is enabled rising input edge

module pwm_sync_deadtime_mask (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Byte writes to buffered values
  input  wire logic        wr_stb_i,
  input  wire logic [3:0]  wr_sel_i,
  input  wire logic        wr_hi_i,
  input  wire logic [7:0]  wr_data_i,
  // Trigger control writes
  input  wire logic        soft_sync_trigger_wr_i,
  input  wire logic        soft_sync_trigger_wr_data_i,
  input  wire logic        trig_wr_i,
  input  wire logic [2:0]  trig_wr_data_i,
  input  wire logic [2:0]  hw_trig_i,
  // Synchronisation configuration
  input  wire logic        sync_mode_sel_i,
  input  wire logic        on_trigger_a_i,
  input  wire logic        mask_sync_en_i,
  input  wire logic        boundary_at_max_i,
  input  wire logic        boundary_at_min_i,
  input  wire logic [2:0]  compare_sync_en_i,
  // Channel configuration
  input  wire logic [2:0]  combine_i,
  input  wire logic [2:0]  complement_i,
  input  wire logic [5:0]  channel_polarity_i,
  input  wire logic        deadtime_enable_i,
  input  wire logic [5:0]  deadtime_count_i,
  input  wire logic [1:0]  deadtime_prescale_i,
  // Status and channel outputs
  output logic [15:0]      counter_value_o,
  output logic             counter_overflow_flag_o,
  output logic             soft_sync_trigger_o,
  output logic [2:0]       hw_trigger_enable_o,
  output logic [5:0]       output_mask_o,
  output logic [5:0]       pwm_o
);

  pwm_sync_pkg::pwm_state_t s_q;
  pwm_sync_pkg::pwm_state_t s_d;

  logic [2:0]  hw_evt;
  logic        hw_any;
  logic        sw_evt;
  logic        imm_mode;
  logic        at_bound;
  logic        bound_load;
  logic        do_load;
  logic        cnt_sync;
  logic        mask_trig;
  logic        wrap;
  logic        cntin_rdy;
  logic [15:0] cntin_next;
  logic [3:0]  ps_last;
  logic        dt_active;
  logic [5:0]  ref_act;
  logic [5:0]  dt_act;
  logic [5:0]  pwm_next;

  // ----------------------------------------------------------------------
  // Trigger events and synchronisation conditions
  // ----------------------------------------------------------------------
  always_comb begin
    hw_evt     = hw_trig_i & ~s_q.trig_prev & s_q.trig_en;
    hw_any     = |hw_evt;
    sw_evt     = soft_sync_trigger_wr_i & soft_sync_trigger_wr_data_i;
    imm_mode   = !sync_mode_sel_i && on_trigger_a_i;
    at_bound   = (boundary_at_max_i && (s_q.cnt == s_q.modv))
               || (boundary_at_min_i && (s_q.cnt == s_q.cntin));
    // Boundary loads wait on a pending trigger
    bound_load = !imm_mode && at_bound
               && (s_q.soft_sync_trigger || (!sync_mode_sel_i && s_q.pend_hw));
    do_load    = (imm_mode && (hw_any || sw_evt)) || bound_load;
    cnt_sync   = on_trigger_a_i
               && (sync_mode_sel_i ? hw_any : (hw_any || sw_evt));
    mask_trig  = sync_mode_sel_i ? hw_any : (hw_any || sw_evt);
    wrap       = (s_q.cnt == s_q.modv);
    cntin_rdy  = s_q.cntin_hi && s_q.cntin_lo;
    cntin_next = (cntin_rdy && (wrap || cnt_sync)) ? s_q.cntin_buf : s_q.cntin;
    unique case (deadtime_prescale_i)
      `PWM_DEADTIME_PRESCALE_DIV4:  ps_last = `PWM_PS_DIV4;
      `PWM_DEADTIME_PRESCALE_DIV16: ps_last = `PWM_PS_DIV16;
      default:         ps_last = `PWM_PS_DIV1;
    endcase
    dt_active  = deadtime_enable_i && (deadtime_count_i != `PWM_DT_ZERO);
  end

  // ----------------------------------------------------------------------
  // Channel reference and output stage, one pair per step
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      logic ref_win;
      logic dt_on;

      // Combine window from compare n up to compare n+1
      always_comb begin
        ref_win = (s_q.cnt >= s_q.cv[2*p]) && (s_q.cnt < s_q.cv[2*p+1]);
        if (combine_i[p]) begin
          ref_act[2*p]   = ref_win;
          ref_act[2*p+1] = complement_i[p] ? ~ref_win : ref_win;
        end else begin
          ref_act[2*p]   = s_q.cnt < s_q.cv[2*p];
          ref_act[2*p+1] = s_q.cnt < s_q.cv[2*p+1];
        end
        dt_on = dt_active && (combine_i[p] || complement_i[p]);
      end

      // Shared delay and tick feed every pair
      pwm_deadtime_pair u_dt (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .a_i       (ref_act[2*p]),
        .b_i       (ref_act[2*p+1]),
        .dt_on_i   (dt_on),
        .tick_i    (s_q.dt_tick),
        .count_i   (deadtime_count_i),
        .a_o       (dt_act[2*p]),
        .b_o       (dt_act[2*p+1])
      );

      // Mask forces inactive level in combine mode, polarity maps active state
      always_comb begin
        pwm_next[2*p] = (s_q.mask[2*p] && combine_i[p])
                      ? channel_polarity_i[2*p]
                      : (dt_act[2*p] ^ channel_polarity_i[2*p]);
        pwm_next[2*p+1] = (s_q.mask[2*p+1] && combine_i[p])
                        ? channel_polarity_i[2*p+1]
                        : (dt_act[2*p+1] ^ channel_polarity_i[2*p+1]);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state of buffers, counter, flags and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.trig_prev = hw_trig_i;

    // Counter: reload at overflow or synchronisation
    s_d.ovf   = wrap;
    s_d.cntin = cntin_next;
    if (cntin_rdy && (wrap || cnt_sync)) begin
      s_d.cntin_hi = 1'b0;
      s_d.cntin_lo = 1'b0;
    end
    if (cnt_sync || wrap) begin
      s_d.cnt = cntin_next;
    end else begin
      s_d.cnt = s_q.cnt + `PWM_CNT_STEP;
    end

    // Modulo and compares from complete buffers
    if (do_load && s_q.mod_hi && s_q.mod_lo) begin
      s_d.modv   = s_q.mod_buf;
      s_d.mod_hi = 1'b0;
      s_d.mod_lo = 1'b0;
    end
    for (int k = 0; k < 6; k++) begin
      if (do_load && compare_sync_en_i[k/2] && s_q.cv_hi[k] && s_q.cv_lo[k]) begin
        s_d.cv[k]    = s_q.cv_buf[k];
        s_d.cv_hi[k] = 1'b0;
        s_d.cv_lo[k] = 1'b0;
      end
    end

    // Byte writes into the write buffers
    if (wr_stb_i) begin
      if (wr_sel_i == `PWM_SEL_CNTIN) begin
        if (wr_hi_i) begin
          s_d.cntin_buf[15:8] = wr_data_i;
          s_d.cntin_hi        = 1'b1;
        end else begin
          s_d.cntin_buf[7:0] = wr_data_i;
          s_d.cntin_lo       = 1'b1;
        end
      end else if (wr_sel_i == `PWM_SEL_MOD) begin
        if (wr_hi_i) begin
          s_d.mod_buf[15:8] = wr_data_i;
          s_d.mod_hi        = 1'b1;
        end else begin
          s_d.mod_buf[7:0] = wr_data_i;
          s_d.mod_lo       = 1'b1;
        end
      end else if (wr_sel_i == `PWM_SEL_MASK) begin
        s_d.mask_buf = wr_data_i[5:0];
      end else if (wr_sel_i >= `PWM_SEL_CV0 && wr_sel_i <= `PWM_SEL_CV5) begin
        for (int k = 0; k < 6; k++) begin
          if (wr_sel_i == `PWM_SEL_CV0 + k[3:0]) begin
            if (wr_hi_i) begin
              s_d.cv_buf[k][15:8] = wr_data_i;
              s_d.cv_hi[k]        = 1'b1;
            end else begin
              s_d.cv_buf[k][7:0] = wr_data_i;
              s_d.cv_lo[k]       = 1'b1;
            end
          end
        end
      end
    end

    // Visible mask follows the buffer directly or on trigger
    if (!mask_sync_en_i || mask_trig) begin
      s_d.mask = s_d.mask_buf;
    end

    // Pending hardware trigger for boundary mode
    if (bound_load) begin
      s_d.pend_hw = 1'b0;
    end
    if (!sync_mode_sel_i && !on_trigger_a_i && hw_any) begin
      s_d.pend_hw = 1'b1;
    end

    // Software trigger flag: hardware clear, a write wins
    if (s_q.soft_sync_trigger && (bound_load || imm_mode)) begin
      s_d.soft_sync_trigger = 1'b0;
    end
    if (soft_sync_trigger_wr_i) begin
      s_d.soft_sync_trigger = soft_sync_trigger_wr_data_i;
    end

    // Hardware trigger enables clear on their event, a write wins
    s_d.trig_en = s_q.trig_en & ~hw_evt;
    if (trig_wr_i) begin
      s_d.trig_en = trig_wr_data_i;
    end

    // Shared deadtime prescaler
    if (s_q.ps_cnt >= ps_last) begin
      s_d.ps_cnt  = `PWM_PS_DIV1;
      s_d.dt_tick = 1'b1;
    end else begin
      s_d.ps_cnt  = s_q.ps_cnt + `PWM_PS_STEP;
      s_d.dt_tick = 1'b0;
    end

    s_d.pwm = pwm_next;

    // Synchronous reset values
    if (srst_i) begin
      s_d           = '0;
      s_d.cnt       = `PWM_CNT_RST;
      s_d.cntin     = `PWM_CNTIN_RST;
      s_d.modv      = `PWM_MOD_RST;
      s_d.mod_buf   = `PWM_MOD_RST;
      s_d.mask      = `PWM_MASK_RST;
      s_d.mask_buf  = `PWM_MASK_RST;
      s_d.trig_en   = `PWM_TRIG_RST;
      s_d.trig_prev = `PWM_TRIG_RST;
      for (int k = 0; k < 6; k++) begin
        s_d.cv[k] = `PWM_CV_RST;
      end
    end
  end

  // State register, all updates on the system clock
  always_ff @(posedge clk_sys_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------------
  assign counter_value_o         = s_q.cnt;
  assign counter_overflow_flag_o = s_q.ovf;
  assign soft_sync_trigger_o     = s_q.soft_sync_trigger;
  assign hw_trigger_enable_o     = s_q.trig_en;
  assign output_mask_o           = s_q.mask;
  assign pwm_o                   = s_q.pwm;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_trig_clear;
    @(posedge clk_sys_i) disable iff (srst_i)
    (hw_any && !trig_wr_i) |=> ((hw_trigger_enable_o & $past(hw_evt)) == 3'h0);
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger enable kept");

  property p_mask_direct;
    @(posedge clk_sys_i) disable iff (srst_i)
    (!mask_sync_en_i && wr_stb_i && wr_sel_i == `PWM_SEL_MASK)
      |=> output_mask_o == $past(wr_data_i[5:0]);
  endproperty
  a_mask_direct: assert property (p_mask_direct) else $error("mask write late");

  property p_mask_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
    (mask_sync_en_i && !mask_trig) |=> $stable(output_mask_o);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask moved untriggered");

  property p_imm_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    (imm_mode && (sw_evt || hw_any) && s_q.mod_hi && s_q.mod_lo)
      |=> s_q.modv == $past(s_q.mod_buf);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("modulo not loaded");

  property p_hw_no_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    (sync_mode_sel_i && !at_bound) |=> $stable(s_q.modv);
  endproperty
  a_hw_no_load: assert property (p_hw_no_load) else $error("modulo off boundary");

  property p_cnt_sync;
    @(posedge clk_sys_i) disable iff (srst_i)
    cnt_sync |=> counter_value_o == $past(cntin_next);
  endproperty
  a_cnt_sync: assert property (p_cnt_sync) else $error("counter not forced");

  property p_sw_clear;
    @(posedge clk_sys_i) disable iff (srst_i)
    (bound_load && s_q.soft_sync_trigger && !soft_sync_trigger_wr_i) |=> !soft_sync_trigger_o;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("soft trigger not cleared");

  property p_cv_gate;
    @(posedge clk_sys_i) disable iff (srst_i)
    !compare_sync_en_i[0] |=> $stable(s_q.cv[0]);
  endproperty
  a_cv_gate: assert property (p_cv_gate) else $error("compare loaded ungated");

  property p_masked_out;
    @(posedge clk_sys_i) disable iff (srst_i)
    (s_q.mask[0] && combine_i[0]) |=> pwm_o[0] == $past(channel_polarity_i[0]);
  endproperty
  a_masked_out: assert property (p_masked_out) else $error("masked channel active");

endmodule : pwm_sync_deadtime_mask
`default_nettype wire

// ### bench/gate_driver_model.sv
// Gate driver model that counts shoot-through cycles on any bridge leg
`timescale 1ns/1ps
`default_nettype none

module gate_driver_model (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic [5:0] gate_i,      // Channel outputs of the stage
  input  wire logic [5:0] polarity_i,  // Inactive level of each channel
  output int              overlap_o    // Cycles with both switches of a leg on
);
  logic [5:0] on_w;

  // A switch conducts while its gate is away from the inactive level
  assign on_w = gate_i ^ polarity_i;

  // Count cycles in which one leg would short the supply
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      overlap_o <= 0;
    end else if ((on_w[0] && on_w[1]) || (on_w[2] && on_w[3]) || (on_w[4] && on_w[5])) begin
      overlap_o <= overlap_o + 1;
    end
  end
endmodule : gate_driver_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench for the PWM synchronisation, deadtime and mask stage
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_regs.svh"

module tb;
  logic        clk_sys_i, srst_i, wr_stb_i, wr_hi_i, soft_sync_trigger_wr_i, soft_sync_trigger_wr_data_i;
  logic        trig_wr_i, sync_mode_sel_i, on_trigger_a_i, mask_sync_en_i;
  logic        boundary_at_max_i, boundary_at_min_i, deadtime_enable_i;
  logic        counter_overflow_flag_o, soft_sync_trigger_o;
  logic [3:0]  wr_sel_i;
  logic [7:0]  wr_data_i;
  logic [2:0]  trig_wr_data_i, hw_trig_i, compare_sync_en_i, combine_i, complement_i;
  logic [2:0]  hw_trigger_enable_o;
  logic [5:0]  channel_polarity_i, deadtime_count_i, output_mask_o, pwm_o;
  logic [1:0]  deadtime_prescale_i;
  logic [15:0] counter_value_o;
  int          overlap, err_total, checks_done;

  pwm_sync_deadtime_mask i_pwm_sync_deadtime_mask (
    .clk_sys_i, .srst_i, .wr_stb_i, .wr_sel_i, .wr_hi_i, .wr_data_i, .soft_sync_trigger_wr_i,
    .soft_sync_trigger_wr_data_i, .trig_wr_i, .trig_wr_data_i, .hw_trig_i, .sync_mode_sel_i,
    .on_trigger_a_i, .mask_sync_en_i, .boundary_at_max_i, .boundary_at_min_i,
    .compare_sync_en_i, .combine_i, .complement_i, .channel_polarity_i, .deadtime_enable_i,
    .deadtime_count_i, .deadtime_prescale_i, .counter_value_o, .counter_overflow_flag_o,
    .soft_sync_trigger_o, .hw_trigger_enable_o, .output_mask_o, .pwm_o);

  gate_driver_model i_gate_driver_model (
    .clk_sys_i, .srst_i, .gate_i(pwm_o), .polarity_i(channel_polarity_i), .overlap_o(overlap));

  // 50 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // One byte write; the strobe drops one edge later
  task automatic wr_byte(input logic [3:0] sel, input logic hi, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_stb_i  <= 1'b1;
    wr_sel_i  <= sel;
    wr_hi_i   <= hi;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_stb_i  <= 1'b0;
  endtask : wr_byte

  task automatic wr_val(input logic [3:0] sel, input logic [15:0] v);
    wr_byte(sel, 1'b1, v[15:8]);
    wr_byte(sel, 1'b0, v[7:0]);
  endtask : wr_val

  task automatic sw_trig(input logic v);
    @(posedge clk_sys_i);
    soft_sync_trigger_wr_i      <= 1'b1;
    soft_sync_trigger_wr_data_i <= v;
    @(posedge clk_sys_i);
    soft_sync_trigger_wr_i      <= 1'b0;
  endtask : sw_trig

  task automatic trig_wr(input logic [2:0] v);
    @(posedge clk_sys_i);
    trig_wr_i      <= 1'b1;
    trig_wr_data_i <= v;
    @(posedge clk_sys_i);
    trig_wr_i      <= 1'b0;
  endtask : trig_wr

  task automatic hw_pulse(input int k);
    @(posedge clk_sys_i);
    hw_trig_i[k] <= 1'b1;
    @(posedge clk_sys_i);
    hw_trig_i[k] <= 1'b0;
  endtask : hw_pulse

  task automatic cfg_sync(input logic mode, input logic trig_a, input logic msync);
    @(posedge clk_sys_i);
    sync_mode_sel_i <= mode;
    on_trigger_a_i  <= trig_a;
    mask_sync_en_i  <= msync;
  endtask : cfg_sync

  task automatic set_dt(input logic en, input logic [5:0] cnt, input logic [5:0] pol,
                        input logic [2:0] comb);
    @(posedge clk_sys_i);
    deadtime_enable_i  <= en;
    deadtime_count_i   <= cnt;
    channel_polarity_i <= pol;
    combine_i          <= comb;
  endtask : set_dt

  task automatic wait_ovf;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (counter_overflow_flag_o !== 1'b1 && n < 100);
    chk({15'h0000, counter_overflow_flag_o}, 16'h0001, "overflow pulse");
  endtask : wait_ovf

  // Cycles between two overflows, and counter restart value
  task automatic chk_period(input int exp, input logic [15:0] init, input string what);
    int n;
    wait_ovf();
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (counter_overflow_flag_o !== 1'b1 && n < 100);
    chk(n[15:0], exp[15:0], what);
    chk(counter_value_o, init, "restart value");
  endtask : chk_period

  // Active cycles of channels 0 and 1 over one 16-cycle period
  task automatic pair_cnt(input int e0, input int e1, input int eov, input string what);
    int c0, c1, ov;
    c0 = 0;
    c1 = 0;
    repeat (24) @(negedge clk_sys_i);
    ov = overlap;
    repeat (16) begin
      @(negedge clk_sys_i);
      c0 += int'(pwm_o[0] !== channel_polarity_i[0]);
      c1 += int'(pwm_o[1] !== channel_polarity_i[1]);
    end
    chk(c0[15:0], e0[15:0], what);
    chk(c1[15:0], e1[15:0], what);
    ov = overlap - ov;
    chk(ov[15:0], eov[15:0], "shoot-through cycles");
  endtask : pair_cnt

  // Watchdog
  initial begin
    #60000;
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    {srst_i, wr_stb_i, wr_hi_i, soft_sync_trigger_wr_i, soft_sync_trigger_wr_data_i, trig_wr_i} = 6'h20;
    {sync_mode_sel_i, on_trigger_a_i, mask_sync_en_i, boundary_at_max_i} = 4'h0;
    {boundary_at_min_i, deadtime_enable_i, deadtime_prescale_i} = 4'h8;
    {wr_sel_i, wr_data_i, trig_wr_data_i, hw_trig_i} = 18'h00000;
    {compare_sync_en_i, combine_i, complement_i} = 9'h049;
    {channel_polarity_i, deadtime_count_i} = 12'h000;
    err_total = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    // Immediate mode: trigger loads modulo and restarts the counter
    cfg_sync(1'b0, 1'b1, 1'b0);
    wr_val(`PWM_SEL_CNTIN, 16'h0004);
    wr_val(`PWM_SEL_MOD, 16'h0013);
    sw_trig(1'b1);
    repeat (3) @(negedge clk_sys_i);
    chk({15'h0000, soft_sync_trigger_o}, 16'h0000, "soft flag after immediate sync");
    chk_period(16, 16'h0004, "immediate modulo load");
    // Boundary mode: load waits for trigger, then for the minimum boundary
    cfg_sync(1'b0, 1'b0, 1'b0);
    wr_val(`PWM_SEL_MOD, 16'h0017);
    chk_period(16, 16'h0004, "no load without trigger");
    sw_trig(1'b1);
    repeat (3) @(negedge clk_sys_i);
    chk({15'h0000, soft_sync_trigger_o}, 16'h0001, "soft flag pending");
    wait_ovf();
    @(negedge clk_sys_i);
    chk({15'h0000, soft_sync_trigger_o}, 16'h0000, "soft flag at boundary");
    chk_period(20, 16'h0004, "boundary modulo load");
    // Mode one: hardware trigger leaves modulo alone, software trigger loads
    cfg_sync(1'b1, 1'b0, 1'b0);
    trig_wr(3'h1);
    wr_val(`PWM_SEL_MOD, 16'h0013);
    hw_pulse(0);
    repeat (2) @(negedge clk_sys_i);
    chk({13'h0000, hw_trigger_enable_o}, 16'h0000, "enable cleared");
    chk_period(20, 16'h0004, "hardware trigger ignored");
    sw_trig(1'b1);
    wait_ovf();
    chk_period(16, 16'h0004, "software trigger load");
    trig_wr(3'h6);
    hw_pulse(0);
    hw_pulse(1);
    repeat (2) @(negedge clk_sys_i);
    chk({13'h0000, hw_trigger_enable_o}, 16'h0004, "only fired enable clears");
    // Output mask, direct and through its write buffer
    cfg_sync(1'b0, 1'b0, 1'b0);
    wr_byte(`PWM_SEL_MASK, 1'b0, 8'h2a);
    @(negedge clk_sys_i);
    chk({10'h000, output_mask_o}, 16'h002a, "direct mask");
    cfg_sync(1'b0, 1'b0, 1'b1);
    wr_byte(`PWM_SEL_MASK, 1'b0, 8'h15);
    repeat (3) @(negedge clk_sys_i);
    chk({10'h000, output_mask_o}, 16'h002a, "mask held in buffer");
    sw_trig(1'b1);
    repeat (3) @(negedge clk_sys_i);
    chk({10'h000, output_mask_o}, 16'h0015, "mask on software trigger");
    cfg_sync(1'b1, 1'b0, 1'b1);
    wr_byte(`PWM_SEL_MASK, 1'b0, 8'h00);
    sw_trig(1'b1);
    repeat (3) @(negedge clk_sys_i);
    chk({10'h000, output_mask_o}, 16'h0015, "software trigger in mode one");
    trig_wr(3'h1);
    hw_pulse(0);
    repeat (3) @(negedge clk_sys_i);
    chk({10'h000, output_mask_o}, 16'h0000, "mask on hardware trigger");
    // Deadtime on pair 0: compares 6 and 14, counter 4 to 19
    cfg_sync(1'b0, 1'b1, 1'b0);
    wr_val(`PWM_SEL_CV0, 16'h0006);
    wr_val(4'h3, 16'h000e);
    sw_trig(1'b1);
    compare_sync_en_i <= 3'h6;
    wr_val(`PWM_SEL_CV0, 16'h0002);
    sw_trig(1'b1);
    set_dt(1'b0, 6'h03, 6'h00, 3'h1);
    pair_cnt(8, 8, 0, "deadtime disabled");
    set_dt(1'b1, 6'h00, 6'h00, 3'h1);
    pair_cnt(8, 8, 0, "zero deadtime");
    set_dt(1'b1, 6'h03, 6'h00, 3'h1);
    pair_cnt(5, 5, 0, "three clock deadtime");
    set_dt(1'b1, 6'h03, 6'h03, 3'h1);
    pair_cnt(5, 5, 0, "active low pair");
    set_dt(1'b1, 6'h08, 6'h00, 3'h1);
    pair_cnt(0, 0, 0, "deadtime covers duty");
    set_dt(1'b0, 6'h03, 6'h00, 3'h1);
    wr_byte(`PWM_SEL_MASK, 1'b0, 8'h01);
    pair_cnt(0, 8, 0, "masked channel");
    set_dt(1'b1, 6'h03, 6'h00, 3'h0);
    complement_i <= 3'h0;
    pair_cnt(2, 10, 2, "pair not combined");
    finish_test();
  end
endmodule : tb
`default_nettype wire
